// *** design/cpu_map_pkg.sv ***
// Constants for the CPU register set and internal memory map.
// Assumes a single core clock and a synchronous active-low core reset.
package cpu_map_pkg;

  // ----------------------------------------
  // Memory sizes and regions
  // ----------------------------------------
  localparam int RAM_DEPTH = 256;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] RAM_BYTE_MASK = 8'hff;

  // ----------------------------------------
  // Special register addresses (direct addressing, 80h and up)
  // ----------------------------------------
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'he0;
  localparam logic [7:0] ADDR_MUL_DIV_PARTNER = 8'hf0;
  localparam logic [7:0] ADDR_CPU_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_POINTER_LOW_BYTE = 8'h82;
  localparam logic [7:0] ADDR_POINTER_HIGH_BYTE = 8'h83;
  localparam logic [7:0] ADDR_MEM_PAGE = 8'h84;

  // ----------------------------------------
  // Status word bit positions
  // ----------------------------------------
  localparam int CARRY_FLAG = 7;
  localparam int HALF_CARRY_FLAG = 6;
  localparam int USER_FLAG0 = 5;
  localparam int BANK_SELECT_HIGH = 4;
  localparam int BANK_SELECT_LOW = 3;
  localparam int SIGNED_WRAP_FLAG = 2;
  localparam int USER_FLAG1 = 1;
  localparam int PARITY_FLAG = 0;

  // ----------------------------------------
  // Reset values and vectors
  // ----------------------------------------
  localparam logic [7:0] ACCUMULATOR_RESET = 8'h00;
  localparam logic [7:0] MUL_DIV_PARTNER_RESET = 8'h00;
  localparam logic [7:0] STACK_POINTER_RESET = 8'h07;
  localparam logic [7:1] CPU_STATUS_WORD_RESET = 7'h00;
  localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;
  localparam logic [7:0] MEM_PAGE_RESET = 8'h00;
  localparam logic [15:0] FETCH_ADDR_RESET = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;

endpackage : cpu_map_pkg

// *** design/ram_port_if.sv ***
// Single access port between the register map and the internal RAM.
// Assumes one access per cycle, read data combinational from the address.
`timescale 1ns/1ps
interface ram_port_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] wmask;
  logic wr;
  logic [7:0] rdata;
  modport user (output addr, output wdata, output wmask, output wr, input rdata);
  modport store (input addr, input wdata, input wmask, input wr, output rdata);
endinterface : ram_port_if

// *** design/internal_ram.sv ***
// The 256-byte internal RAM, one bit lane per generate slice.
// Assumes the user side holds at most one access per cycle.
`timescale 1ns/1ps
module internal_ram (
  input wire logic clk,
  ram_port_if.store port
);

  // ----------------------------------------
  // Bit lanes
  // ----------------------------------------
  // Per-lane storage lets a single bit be written without read-modify-write
  for (genvar i = 0; i < 8; i++) begin : g_lane
    logic [cpu_map_pkg::RAM_DEPTH-1:0] lane;
    always_ff @(posedge clk) begin
      if (port.wr && port.wmask[i]) begin
        lane[port.addr] <= port.wdata[i];
      end
    end
    assign port.rdata[i] = lane[port.addr];
  end

endmodule : internal_ram

// *** design/cpu_register_memory_map.sv ***
// Architectural registers and internal memory map of the CPU core.
// Assumes the execution unit raises at most one access group per cycle.
//
// Summary of operation
// - Separate program and data spaces; flash read-only except during update.
// - Page register extends the 64K address.
// - Stack pointer pre-increments on push; grows upward.
// - Stack pointer resets to 07h.
// - Program counter is two bytes, next fetch.
// - Fetch address zero after reset.
// - Interrupt vectors at 0003h, eight bytes apart.
// - Status word bank bits pick register bank.
// - Bytes 20h-2Fh hold 128 addressable bits.
// - 256-byte internal RAM also holds stack.
// - Special registers 80h-FFh reached directly only.
// - Special registers ending 0h/8h bit-addressable.
// - Carry captures ALU carry, shifts, rotates.
// - Half carry from bit 3 or 4.
// - Signed wrap flag on signed overflow.
// - Parity keeps accumulator ones count even.
// - Accumulator and partner form 16-bit pair.
// - Data pointer is 16 bits, external address.
`timescale 1ns/1ps
module cpu_register_memory_map (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [7:0] DIR_ADDR,
  input wire logic DIR_RD,
  input wire logic DIR_WR,
  input wire logic [7:0] DIR_WDATA,
  input wire logic [7:0] IND_ADDR,
  input wire logic IND_RD,
  input wire logic IND_WR,
  input wire logic [7:0] IND_WDATA,
  input wire logic [2:0] REG_SEL,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] BIT_ADDR,
  input wire logic BIT_RD,
  input wire logic BIT_WR,
  input wire logic BIT_WDATA,
  input wire logic PUSH,
  input wire logic [7:0] PUSH_DATA,
  input wire logic POP,
  input wire logic ACC_WR,
  input wire logic [7:0] ACC_WDATA,
  input wire logic PAIR_WR,
  input wire logic [15:0] PAIR_WDATA,
  input wire logic [2:0] FLAG_WR,
  input wire logic [2:0] FLAG_IN,
  input wire logic PC_INC,
  input wire logic PC_LOAD,
  input wire logic [15:0] PC_LOAD_VALUE,
  input wire logic VECTOR_TAKE,
  input wire logic [2:0] VECTOR_NUM,
  input wire logic PTR_INC,
  input wire logic PTR_LOAD,
  input wire logic [15:0] PTR_LOAD_VALUE,
  input wire logic FLASH_WR_REQ,
  input wire logic FLASH_UPDATE,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic [15:0] FETCH_ADDR,
  output logic [7:0] MEM_PAGE,
  output logic [7:0] ACCUMULATOR,
  output logic [7:0] MUL_DIV_PARTNER,
  output logic [7:0] STACK_POINTER,
  output logic [7:0] CPU_STATUS_WORD,
  output logic [15:0] DATA_POINTER,
  output logic FLASH_WR_EN
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] bit_byte_addr(input logic [7:0] ba);
    logic [7:0] r;
    if (ba[7]) begin
      r = {ba[7:3], 3'b000};
    end else begin
      r = cpu_map_pkg::BIT_RAM_BASE | {4'h0, ba[6:3]};
    end
    return r;
  endfunction : bit_byte_addr

  function automatic logic [7:0] bit_mask(input logic [7:0] ba);
    return 8'h01 << ba[2:0];
  endfunction : bit_mask

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                       input logic [7:0] mask);
    return (old & ~mask) | (data & mask);
  endfunction : merge

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] accumulator;
  logic [7:0] mul_div_partner;
  logic [7:0] stack_pointer;
  logic [7:1] cpu_status_word;
  logic parity_flag;
  logic [7:0] pointer_high_byte;
  logic [7:0] pointer_low_byte;
  logic [7:0] fetch_addr_high;
  logic [7:0] fetch_addr_low;
  logic [7:0] mem_page;
  logic [7:0] next_acc;
  logic [1:0] bank;

  // ----------------------------------------
  // Access arbitration
  // ----------------------------------------
  // Fixed priority guards the single RAM port if the core overlaps requests
  logic op_push, op_pop, op_reg, op_ind, op_dir, op_bit;
  assign op_push = PUSH;
  assign op_pop = POP && !op_push;
  assign op_reg = (REG_RD || REG_WR) && !PUSH && !POP;
  assign op_ind = (IND_RD || IND_WR) && !PUSH && !POP && !op_reg;
  assign op_dir = (DIR_RD || DIR_WR) && !PUSH && !POP && !op_reg && !op_ind;
  assign op_bit = (BIT_RD || BIT_WR) && !PUSH && !POP && !op_reg && !op_ind && !op_dir;

  assign bank = {cpu_status_word[cpu_map_pkg::BANK_SELECT_HIGH],
                 cpu_status_word[cpu_map_pkg::BANK_SELECT_LOW]};

  logic [7:0] bit_byte;
  logic [7:0] bmask;
  assign bit_byte = bit_byte_addr(BIT_ADDR);
  assign bmask = bit_mask(BIT_ADDR);

  // ----------------------------------------
  // RAM port
  // ----------------------------------------
  ram_port_if ram ();

  internal_ram u_ram (
    .clk(SYS_CLK),
    .port(ram)
  );

  always_comb begin
    ram.addr = 8'h00;
    ram.wdata = 8'h00;
    ram.wmask = cpu_map_pkg::RAM_BYTE_MASK;
    ram.wr = 1'b0;
    if (op_push) begin
      ram.addr = stack_pointer + 8'h01;
      ram.wdata = PUSH_DATA;
      ram.wr = 1'b1;
    end else if (op_pop) begin
      ram.addr = stack_pointer;
    end else if (op_reg) begin
      ram.addr = {3'b000, bank, REG_SEL};
      ram.wdata = REG_WDATA;
      ram.wr = REG_WR;
    end else if (op_ind) begin
      ram.addr = IND_ADDR;
      ram.wdata = IND_WDATA;
      ram.wr = IND_WR;
    end else if (op_dir && !DIR_ADDR[7]) begin
      ram.addr = DIR_ADDR;
      ram.wdata = DIR_WDATA;
      ram.wr = DIR_WR;
    end else if (op_bit && !BIT_ADDR[7]) begin
      ram.addr = bit_byte;
      ram.wdata = {8{BIT_WDATA}};
      ram.wmask = bmask;
      ram.wr = BIT_WR;
    end
  end

  // ----------------------------------------
  // Special register access
  // ----------------------------------------
  // Only direct and bit operations reach this space, never indirect ones
  logic spc_wr;
  logic [7:0] spc_addr;
  logic [7:0] spc_wdata;
  logic [7:0] spc_wmask;
  logic [7:0] spc_rdata;

  always_comb begin
    spc_wr = 1'b0;
    spc_addr = bit_byte;
    spc_wdata = {8{BIT_WDATA}};
    spc_wmask = bmask;
    if (op_dir && DIR_ADDR[7]) begin
      spc_wr = DIR_WR;
      spc_addr = DIR_ADDR;
      spc_wdata = DIR_WDATA;
      spc_wmask = cpu_map_pkg::RAM_BYTE_MASK;
    end else if (op_bit && BIT_ADDR[7]) begin
      spc_wr = BIT_WR;
    end
  end

  always_comb begin
    unique case (spc_addr)
      cpu_map_pkg::ADDR_ACCUMULATOR: spc_rdata = accumulator;
      cpu_map_pkg::ADDR_MUL_DIV_PARTNER: spc_rdata = mul_div_partner;
      cpu_map_pkg::ADDR_CPU_STATUS_WORD: spc_rdata = {cpu_status_word, parity_flag};
      cpu_map_pkg::ADDR_STACK_POINTER: spc_rdata = stack_pointer;
      cpu_map_pkg::ADDR_POINTER_LOW_BYTE: spc_rdata = pointer_low_byte;
      cpu_map_pkg::ADDR_POINTER_HIGH_BYTE: spc_rdata = pointer_high_byte;
      cpu_map_pkg::ADDR_MEM_PAGE: spc_rdata = mem_page;
      default: spc_rdata = 8'h00;
    endcase
  end

  logic wr_acc, wr_partner, wr_status, wr_stack, wr_ptr_low, wr_ptr_high, wr_page;
  assign wr_acc = spc_wr && (spc_addr == cpu_map_pkg::ADDR_ACCUMULATOR);
  assign wr_partner = spc_wr && (spc_addr == cpu_map_pkg::ADDR_MUL_DIV_PARTNER);
  assign wr_status = spc_wr && (spc_addr == cpu_map_pkg::ADDR_CPU_STATUS_WORD);
  assign wr_stack = spc_wr && (spc_addr == cpu_map_pkg::ADDR_STACK_POINTER);
  assign wr_ptr_low = spc_wr && (spc_addr == cpu_map_pkg::ADDR_POINTER_LOW_BYTE);
  assign wr_ptr_high = spc_wr && (spc_addr == cpu_map_pkg::ADDR_POINTER_HIGH_BYTE);
  assign wr_page = spc_wr && (spc_addr == cpu_map_pkg::ADDR_MEM_PAGE);

  // ----------------------------------------
  // Read return
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= op_pop || (op_reg && REG_RD) || (op_ind && IND_RD) ||
                  (op_dir && DIR_RD) || (op_bit && BIT_RD);
      if (op_dir && DIR_ADDR[7]) begin
        RD_DATA <= spc_rdata;
      end else if (op_bit) begin
        RD_DATA <= {7'h00, |((BIT_ADDR[7] ? spc_rdata : ram.rdata) & bmask)};
      end else begin
        RD_DATA <= ram.rdata;
      end
    end
  end

  // ----------------------------------------
  // Accumulator, partner and parity
  // ----------------------------------------
  always_comb begin
    next_acc = accumulator;
    if (PAIR_WR) begin
      next_acc = PAIR_WDATA[7:0];
    end else if (ACC_WR) begin
      next_acc = ACC_WDATA;
    end else if (wr_acc) begin
      next_acc = merge(accumulator, spc_wdata, spc_wmask);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      accumulator <= cpu_map_pkg::ACCUMULATOR_RESET;
      parity_flag <= 1'b0;
    end else begin
      accumulator <= next_acc;
      parity_flag <= ^next_acc;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      mul_div_partner <= cpu_map_pkg::MUL_DIV_PARTNER_RESET;
    end else if (PAIR_WR) begin
      mul_div_partner <= PAIR_WDATA[15:8];
    end else if (wr_partner) begin
      mul_div_partner <= merge(mul_div_partner, spc_wdata, spc_wmask);
    end
  end

  // ----------------------------------------
  // Stack pointer
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      stack_pointer <= cpu_map_pkg::STACK_POINTER_RESET;
    end else if (op_push) begin
      stack_pointer <= stack_pointer + 8'h01;
    end else if (op_pop) begin
      stack_pointer <= stack_pointer - 8'h01;
    end else if (wr_stack) begin
      stack_pointer <= merge(stack_pointer, spc_wdata, spc_wmask);
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  // ALU flag results win over a software write in the same cycle
  logic [7:0] status_merged;
  assign status_merged = merge({cpu_status_word, parity_flag}, spc_wdata, spc_wmask);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      cpu_status_word <= cpu_map_pkg::CPU_STATUS_WORD_RESET;
    end else begin
      if (wr_status) begin
        cpu_status_word <= status_merged[7:1];
      end
      if (FLAG_WR[2]) begin
        cpu_status_word[cpu_map_pkg::CARRY_FLAG] <= FLAG_IN[2];
      end
      if (FLAG_WR[1]) begin
        cpu_status_word[cpu_map_pkg::HALF_CARRY_FLAG] <= FLAG_IN[1];
      end
      if (FLAG_WR[0]) begin
        cpu_status_word[cpu_map_pkg::SIGNED_WRAP_FLAG] <= FLAG_IN[0];
      end
    end
  end

  // ----------------------------------------
  // Data pointer and page
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      {pointer_high_byte, pointer_low_byte} <= cpu_map_pkg::DATA_POINTER_RESET;
    end else if (PTR_LOAD) begin
      {pointer_high_byte, pointer_low_byte} <= PTR_LOAD_VALUE;
    end else if (PTR_INC) begin
      {pointer_high_byte, pointer_low_byte} <= {pointer_high_byte, pointer_low_byte} + 16'h0001;
    end else if (wr_ptr_low) begin
      pointer_low_byte <= merge(pointer_low_byte, spc_wdata, spc_wmask);
    end else if (wr_ptr_high) begin
      pointer_high_byte <= merge(pointer_high_byte, spc_wdata, spc_wmask);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      mem_page <= cpu_map_pkg::MEM_PAGE_RESET;
    end else if (wr_page) begin
      mem_page <= merge(mem_page, spc_wdata, spc_wmask);
    end
  end

  // ----------------------------------------
  // Fetch address
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      {fetch_addr_high, fetch_addr_low} <= cpu_map_pkg::FETCH_ADDR_RESET;
    end else if (VECTOR_TAKE) begin
      {fetch_addr_high, fetch_addr_low} <= cpu_map_pkg::VECTOR_BASE +
                                           {10'h000, VECTOR_NUM, 3'b000};
    end else if (PC_LOAD) begin
      {fetch_addr_high, fetch_addr_low} <= PC_LOAD_VALUE;
    end else if (PC_INC) begin
      {fetch_addr_high, fetch_addr_low} <= {fetch_addr_high, fetch_addr_low} + 16'h0001;
    end
  end

  // ----------------------------------------
  // Flash write guard
  // ----------------------------------------
  // Program space stays read-only unless an update is in progress
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      FLASH_WR_EN <= 1'b0;
    end else begin
      FLASH_WR_EN <= FLASH_WR_REQ && FLASH_UPDATE;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign FETCH_ADDR = {fetch_addr_high, fetch_addr_low};
  assign MEM_PAGE = mem_page;
  assign ACCUMULATOR = accumulator;
  assign MUL_DIV_PARTNER = mul_div_partner;
  assign STACK_POINTER = stack_pointer;
  assign CPU_STATUS_WORD = {cpu_status_word, parity_flag};
  assign DATA_POINTER = {pointer_high_byte, pointer_low_byte};

endmodule : cpu_register_memory_map

// *** verif/cpu_map_assertions.sv ***
// Concurrent checks on the register map's top-level ports.
// Assumes one core clock and the synchronous active-low core reset.
`timescale 1ns/1ps
module cpu_map_assertions (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic PUSH,
  input wire logic POP,
  input wire logic DIR_WR,
  input wire logic IND_WR,
  input wire logic BIT_WR,
  input wire logic ACC_WR,
  input wire logic PAIR_WR,
  input wire logic [15:0] PAIR_WDATA,
  input wire logic PC_INC,
  input wire logic PC_LOAD,
  input wire logic VECTOR_TAKE,
  input wire logic [2:0] VECTOR_NUM,
  input wire logic FLASH_WR_REQ,
  input wire logic FLASH_UPDATE,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic [7:0] ACCUMULATOR,
  input wire logic [7:0] MUL_DIV_PARTNER,
  input wire logic [7:0] STACK_POINTER,
  input wire logic [7:0] CPU_STATUS_WORD,
  input wire logic FLASH_WR_EN
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  a_stack_reset: assert property ($rose(RST_B) |-> STACK_POINTER == 8'h07)
    else $error("stack pointer not 07h after reset");
  a_pc_reset_zero: assert property ($rose(RST_B) |-> FETCH_ADDR == 16'h0000)
    else $error("fetch address not zero after reset");
  a_push_pre_inc: assert property (PUSH |=> STACK_POINTER == $past(STACK_POINTER) + 8'h01)
    else $error("push did not raise stack pointer by one");
  a_pop_dec: assert property (POP && !PUSH |=> STACK_POINTER == $past(STACK_POINTER) - 8'h01)
    else $error("pop did not lower stack pointer by one");
  a_parity_even: assert property (CPU_STATUS_WORD[0] == ^ACCUMULATOR)
    else $error("parity flag does not match accumulator");
  a_vector_addr: assert property (VECTOR_TAKE |=>
      FETCH_ADDR == 16'h0003 + {10'h000, $past(VECTOR_NUM), 3'b000})
    else $error("vector address wrong");
  a_pc_step: assert property (PC_INC && !PC_LOAD && !VECTOR_TAKE |=>
      FETCH_ADDR == $past(FETCH_ADDR) + 16'h0001)
    else $error("fetch address did not step by one");
  a_pair_load: assert property (PAIR_WR |=>
      {MUL_DIV_PARTNER, ACCUMULATOR} == $past(PAIR_WDATA))
    else $error("pair write did not land");
  a_flash_gate: assert property (##1 FLASH_WR_EN == ($past(FLASH_WR_REQ) && $past(FLASH_UPDATE)))
    else $error("flash write enable outside update");
  a_ind_no_spc: assert property (IND_WR && !ACC_WR && !PAIR_WR && !DIR_WR && !BIT_WR |=>
      $stable(ACCUMULATOR))
    else $error("indirect write reached accumulator");
endmodule : cpu_map_assertions

bind cpu_register_memory_map cpu_map_assertions chk (.SYS_CLK, .RST_B, .PUSH, .POP, .DIR_WR,
  .IND_WR, .BIT_WR, .ACC_WR, .PAIR_WR, .PAIR_WDATA, .PC_INC, .PC_LOAD, .VECTOR_TAKE,
  .VECTOR_NUM, .FLASH_WR_REQ, .FLASH_UPDATE, .FETCH_ADDR, .ACCUMULATOR, .MUL_DIV_PARTNER,
  .STACK_POINTER, .CPU_STATUS_WORD, .FLASH_WR_EN);

// *** verif/exec_unit_model.sv ***
// Stand-in for the execution unit: raises one request group per call.
// Assumes requests change at the falling edge and are taken at the next rise.
`timescale 1ns/1ps
module exec_unit_model (
  input wire logic clk,
  input wire logic [7:0] RD_DATA,
  output logic [7:0] DIR_ADDR,
  output logic DIR_RD,
  output logic DIR_WR,
  output logic [7:0] DIR_WDATA,
  output logic [7:0] IND_ADDR,
  output logic IND_RD,
  output logic IND_WR,
  output logic [7:0] IND_WDATA,
  output logic [2:0] REG_SEL,
  output logic REG_RD,
  output logic REG_WR,
  output logic [7:0] REG_WDATA,
  output logic [7:0] BIT_ADDR,
  output logic BIT_RD,
  output logic BIT_WR,
  output logic BIT_WDATA,
  output logic PUSH,
  output logic [7:0] PUSH_DATA,
  output logic POP,
  output logic ACC_WR,
  output logic [7:0] ACC_WDATA,
  output logic PAIR_WR,
  output logic [15:0] PAIR_WDATA,
  output logic [2:0] FLAG_WR,
  output logic [2:0] FLAG_IN,
  output logic PC_INC,
  output logic PC_LOAD,
  output logic [15:0] PC_LOAD_VALUE,
  output logic VECTOR_TAKE,
  output logic [2:0] VECTOR_NUM,
  output logic PTR_INC,
  output logic PTR_LOAD,
  output logic [15:0] PTR_LOAD_VALUE,
  output logic FLASH_WR_REQ,
  output logic FLASH_UPDATE
);
  // ----------------------------------------
  // Request driver
  // ----------------------------------------
  // Kind k: 0..16 one strobe (bit k of the group below), 17 flags, 18 flash mode
  task automatic op(input int k, input logic [15:0] a, input logic [15:0] d,
      output logic [7:0] q);
    @(negedge clk);
    {DIR_ADDR, IND_ADDR, BIT_ADDR} = {3{a[7:0]}};
    {REG_SEL, VECTOR_NUM, FLAG_IN} = {a[2:0], a[2:0], d[2:0]};
    {DIR_WDATA, IND_WDATA, REG_WDATA, PUSH_DATA, ACC_WDATA} = {5{d[7:0]}};
    {BIT_WDATA, PAIR_WDATA, PC_LOAD_VALUE, PTR_LOAD_VALUE} = {d[0], d, a, a};
    {PTR_LOAD, PTR_INC, VECTOR_TAKE, PC_LOAD, PC_INC, PAIR_WR, ACC_WR, POP, PUSH, BIT_RD,
      BIT_WR, REG_RD, REG_WR, IND_RD, IND_WR, DIR_RD, DIR_WR} = 17'h00001 << k;
    FLAG_WR = (k == 17) ? d[5:3] : 3'h0;
    if (k == 18) begin
      {FLASH_WR_REQ, FLASH_UPDATE} = d[1:0];
    end
    // Held across exactly one rising edge so each call is one access
    @(negedge clk);
    q = RD_DATA;
    {PTR_LOAD, PTR_INC, VECTOR_TAKE, PC_LOAD, PC_INC, PAIR_WR, ACC_WR, POP, PUSH, BIT_RD,
      BIT_WR, REG_RD, REG_WR, IND_RD, IND_WR, DIR_RD, DIR_WR} = 17'h00000;
    FLAG_WR = 3'h0;
  endtask : op

  initial begin
    {DIR_ADDR, IND_ADDR, BIT_ADDR, DIR_WDATA, IND_WDATA, REG_WDATA} = 48'h0;
    {PUSH_DATA, ACC_WDATA, PAIR_WDATA, PC_LOAD_VALUE, PTR_LOAD_VALUE} = 64'h0;
    {REG_SEL, VECTOR_NUM, FLAG_IN, FLAG_WR, BIT_WDATA, FLASH_WR_REQ, FLASH_UPDATE} = 15'h0;
    {PTR_LOAD, PTR_INC, VECTOR_TAKE, PC_LOAD, PC_INC, PAIR_WR, ACC_WR, POP, PUSH, BIT_RD,
      BIT_WR, REG_RD, REG_WR, IND_RD, IND_WR, DIR_RD, DIR_WR} = 17'h00000;
  end
endmodule : exec_unit_model

// *** verif/cpu_register_memory_map_tb.sv ***
// Self-checking bench for the register map, driven through the execution-unit model.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module cpu_register_memory_map_tb;
  logic SYS_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [7:0] DIR_ADDR, DIR_WDATA, IND_ADDR, IND_WDATA, REG_WDATA, BIT_ADDR, PUSH_DATA;
  logic [7:0] ACC_WDATA, RD_DATA, MEM_PAGE, ACCUMULATOR, MUL_DIV_PARTNER, STACK_POINTER;
  logic [7:0] CPU_STATUS_WORD;
  logic [2:0] REG_SEL, FLAG_WR, FLAG_IN, VECTOR_NUM;
  logic [15:0] PAIR_WDATA, PC_LOAD_VALUE, PTR_LOAD_VALUE, FETCH_ADDR, DATA_POINTER;
  logic DIR_RD, DIR_WR, IND_RD, IND_WR, REG_RD, REG_WR, BIT_RD, BIT_WR, BIT_WDATA, PUSH, POP;
  logic ACC_WR, PAIR_WR, PC_INC, PC_LOAD, VECTOR_TAKE, PTR_INC, PTR_LOAD, FLASH_WR_REQ;
  logic FLASH_UPDATE, RD_VALID, FLASH_WR_EN;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] pv [4] = '{8'h55, 8'h07, 8'h80, 8'hff};

  always #2.5 SYS_CLK = ~SYS_CLK;

  exec_unit_model ex (.clk(SYS_CLK), .RD_DATA, .DIR_ADDR, .DIR_RD, .DIR_WR, .DIR_WDATA,
    .IND_ADDR, .IND_RD, .IND_WR, .IND_WDATA, .REG_SEL, .REG_RD, .REG_WR, .REG_WDATA, .BIT_ADDR,
    .BIT_RD, .BIT_WR, .BIT_WDATA, .PUSH, .PUSH_DATA, .POP, .ACC_WR, .ACC_WDATA, .PAIR_WR,
    .PAIR_WDATA, .FLAG_WR, .FLAG_IN, .PC_INC, .PC_LOAD, .PC_LOAD_VALUE, .VECTOR_TAKE,
    .VECTOR_NUM, .PTR_INC, .PTR_LOAD, .PTR_LOAD_VALUE, .FLASH_WR_REQ, .FLASH_UPDATE);

  cpu_register_memory_map uut (.SYS_CLK, .RST_B, .DIR_ADDR, .DIR_RD, .DIR_WR, .DIR_WDATA,
    .IND_ADDR, .IND_RD, .IND_WR, .IND_WDATA, .REG_SEL, .REG_RD, .REG_WR, .REG_WDATA, .BIT_ADDR,
    .BIT_RD, .BIT_WR, .BIT_WDATA, .PUSH, .PUSH_DATA, .POP, .ACC_WR, .ACC_WDATA, .PAIR_WR,
    .PAIR_WDATA, .FLAG_WR, .FLAG_IN, .PC_INC, .PC_LOAD, .PC_LOAD_VALUE, .VECTOR_TAKE,
    .VECTOR_NUM, .PTR_INC, .PTR_LOAD, .PTR_LOAD_VALUE, .FLASH_WR_REQ, .FLASH_UPDATE,
    .RD_DATA, .RD_VALID, .FETCH_ADDR, .MEM_PAGE, .ACCUMULATOR, .MUL_DIV_PARTNER,
    .STACK_POINTER, .CPU_STATUS_WORD, .DATA_POINTER, .FLASH_WR_EN);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic t(input int k, input logic [15:0] a, input logic [15:0] d);
    logic [7:0] q;
    ex.op(k, a, d, q);
  endtask : t

  // Read kinds return data one cycle later with the valid pulse
  task automatic rd(input int k, input logic [15:0] a, input logic [7:0] e, input string n);
    logic [7:0] q;
    ex.op(k, a, 16'h0, q);
    chk({n, " valid"}, RD_VALID, 1'b1);
    chk(n, q, e);
  endtask : rd

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // Ceiling well above the roughly 116 cycles the sequence needs
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge SYS_CLK);
    RST_B = 1'b1;
    chk("sp", STACK_POINTER, 8'h07);
    chk("pc", FETCH_ADDR, 16'h0000);
    chk("status", CPU_STATUS_WORD, 8'h00);
    chk("page", MEM_PAGE, 8'h00);
    done("reset");
    t(8, 16'h0, 16'haa);
    chk("sp push", STACK_POINTER, 8'h08);
    rd(1, 16'h08, 8'haa, "ram08");
    t(8, 16'h0, 16'h55);
    rd(9, 16'h0, 8'h55, "pop");
    chk("sp pop", STACK_POINTER, 8'h08);
    done("stack");
    foreach (pv[i]) begin
      t(0, 16'he0, {8'h00, pv[i]});
      chk("acc", ACCUMULATOR, pv[i]);
      chk("parity", CPU_STATUS_WORD[0], ^pv[i]);
    end
    t(10, 16'h0, 16'h07);
    chk("acc wr", {CPU_STATUS_WORD[0], ACCUMULATOR}, 9'h107);
    t(11, 16'h0, 16'h1234);
    chk("pair", {MUL_DIV_PARTNER, ACCUMULATOR}, 16'h1234);
    chk("parity", CPU_STATUS_WORD[0], 1'b1);
    done("accumulator");
    for (int j = 0; j < 4; j++) begin
      t(0, 16'hd0, 16'(j << 3));
      chk("bank", CPU_STATUS_WORD[4:3], 16'(j));
      t(4, 16'h0002, 16'h0040 + 16'(j));
    end
    for (int j = 0; j < 4; j++) begin
      rd(3, 16'(j * 8 + 2), 8'h40 + 8'(j), "bank reg");
    end
    rd(5, 16'h0002, 8'h43, "reg read");
    done("banks");
    t(2, 16'h2f, 16'h0);
    t(2, 16'h20, 16'h0);
    t(6, 16'h7f, 16'h1);
    t(6, 16'h00, 16'h1);
    rd(3, 16'h2f, 8'h80, "byte 2f");
    rd(3, 16'h20, 8'h01, "byte 20");
    rd(7, 16'h7f, 8'h01, "bit 7f");
    t(0, 16'he0, 16'h0);
    t(6, 16'he3, 16'h1);
    chk("sfr bit", ACCUMULATOR, 8'h08);
    done("bits");
    t(2, 16'he0, 16'h5a);
    chk("acc kept", ACCUMULATOR, 8'h08);
    rd(3, 16'he0, 8'h5a, "upper ram");
    rd(1, 16'he0, 8'h08, "direct sfr");
    rd(1, 16'h85, 8'h00, "unmapped");
    done("spaces");
    for (int n = 0; n < 8; n++) begin
      t(14, 16'(n), 16'h0);
      chk("vector", FETCH_ADDR, 16'h0003 + 16'(n * 8));
    end
    t(13, 16'hfffe, 16'h0);
    t(12, 16'h0, 16'h0);
    chk("pc inc", FETCH_ADDR, 16'hffff);
    done("fetch");
    t(16, 16'h12ff, 16'h0);
    t(15, 16'h0, 16'h0);
    chk("data_pointer", DATA_POINTER, 16'h1300);
    rd(1, 16'h83, 8'h13, "data_pointer high");
    t(0, 16'h82, 16'h77);
    chk("data_pointer low", DATA_POINTER, 16'h1377);
    done("pointer");
    t(17, 16'h0, 16'h003d);
    chk("flags", {CPU_STATUS_WORD[7:6], CPU_STATUS_WORD[2]}, 3'b101);
    t(17, 16'h0, 16'h0012);
    chk("flags", {CPU_STATUS_WORD[7:6], CPU_STATUS_WORD[2]}, 3'b111);
    done("flags");
    t(0, 16'h84, 16'h05);
    chk("page", MEM_PAGE, 8'h05);
    t(18, 16'h0, 16'h3);
    chk("flash on", FLASH_WR_EN, 1'b1);
    t(18, 16'h0, 16'h2);
    chk("flash off", FLASH_WR_EN, 1'b0);
    done("memory");
    // Second reset in mid-run, with state far from its reset values
    RST_B = 1'b0;
    repeat (2) @(negedge SYS_CLK);
    RST_B = 1'b1;
    chk("sp", STACK_POINTER, 8'h07);
    chk("pc", FETCH_ADDR, 16'h0000);
    done("rereset");
    results();
  end
endmodule : cpu_register_memory_map_tb
